// ==== bench/tcdma_bus_model.sv ====
// partner: byte-wide memory and i/o space on the far side of the transfer bus
// assumes the design's dma_rd/dma_wr levels; only address bits 7:0 select a cell
`timescale 1ns/1ps
module tcdma_bus_model
	import tcdma_pkg::*;
(
	input wire logic ref_clk,
	input wire logic [tcdma_pkg::MADDR_W-1:0] dma_addr,
	input wire logic dma_is_io,
	input wire logic dma_rd,
	input wire logic dma_wr,
	input wire logic [tcdma_pkg::DATA_W-1:0] dma_wdata,
	input wire logic transfer_end_n,
	output logic [tcdma_pkg::DATA_W-1:0] dma_rdata
);
	logic [7:0] mem [256];
	logic [7:0] io [256];
	logic [7:0] last_q;
	logic wr_q;
	int cyc;
	logic [19:0] wa [$];
	logic [7:0] wd [$];
	logic wte [$];
	int wt [$];

	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'(i) ^ 8'hA5;
			io[i] = ~8'(i);
		end
		last_q = 8'h00;
		wr_q = 1'b0;
		cyc = 0;
	end

	// released bus shows the inverse of the last byte, never a stale copy
	assign dma_rdata = dma_rd ? (dma_is_io ? io[dma_addr[7:0]] : mem[dma_addr[7:0]]) : ~last_q;

	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		wr_q <= dma_wr;
		if (dma_rd)
			last_q <= dma_rdata;
		if (dma_wr && dma_is_io)
			io[dma_addr[7:0]] <= dma_wdata;
		if (dma_wr && !dma_is_io)
			mem[dma_addr[7:0]] <= dma_wdata;
		if (dma_wr && !wr_q) begin
			wa.push_back(dma_addr);
			wd.push_back(dma_wdata);
			wte.push_back(transfer_end_n);
			wt.push_back(cyc);
		end
	end
endmodule : tcdma_bus_model

// ==== bench/testbench.sv ====
// self-checking bench: register port tasks, byte moves checked at the bus model
// assumes the cpu grants the bus one cycle after bus_req
`timescale 1ns/1ps
module testbench;
	import tcdma_pkg::*;
	logic ref_clk, rst_n, io_wr, io_rd, nmi_n, ch0_request_n, ch1_request_n, bus_grant;
	logic [7:0] io_addr, io_wdata, io_rdata, dma_wdata, dma_rdata, v;
	logic [19:0] dma_addr;
	logic dma_is_io, dma_rd, dma_wr, bus_req, transfer_end_n, ch0_irq, ch1_irq;
	logic [1:0] mem_wait_count, io_wait_count;
	int n_fail, n_checks, nn;

	tcdma_top u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .io_addr(io_addr), .io_wr(io_wr),
		.io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .nmi_n(nmi_n),
		.ch0_request_n(ch0_request_n), .ch1_request_n(ch1_request_n), .bus_req(bus_req),
		.bus_grant(bus_grant), .dma_addr(dma_addr), .dma_is_io(dma_is_io), .dma_rd(dma_rd),
		.dma_wr(dma_wr), .dma_wdata(dma_wdata), .dma_rdata(dma_rdata),
		.transfer_end_n(transfer_end_n), .ch0_irq(ch0_irq), .ch1_irq(ch1_irq),
		.mem_wait_count(mem_wait_count), .io_wait_count(io_wait_count));
	tcdma_bus_model m (.ref_clk(ref_clk), .dma_addr(dma_addr), .dma_is_io(dma_is_io),
		.dma_rd(dma_rd), .dma_wr(dma_wr), .dma_wdata(dma_wdata),
		.transfer_end_n(transfer_end_n), .dma_rdata(dma_rdata));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// cpu side simply hands the bus over a cycle after it is asked
	always @(posedge ref_clk) bus_grant <= bus_req;

	task report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : report_and_stop

	task chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		io_addr <= a;
		io_wdata <= d;
		io_wr <= 1'b1;
		@(posedge ref_clk);
		io_wr <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		io_addr <= a;
		io_rd <= 1'b1;
		@(posedge ref_clk);
		io_rd <= 1'b0;
		#1 d = io_rdata;
	endtask : rd

	task rchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		chk(nm, d, exp);
	endtask : rchk

	// multi-byte registers go low byte first
	task wreg(input logic [7:0] a, input logic [19:0] val, input int n);
		for (int i = 0; i < n; i++)
			wr(a + 8'(i), 8'(val >> (8 * i)));
	endtask : wreg

	task ch0(input logic [19:0] s, input logic [19:0] d, input logic [19:0] c,
		input logic [7:0] mode, input logic [7:0] ctrl);
		wreg(OFS_SAR, s, 3);
		wreg(OFS_DAR, d, 3);
		wreg(OFS_BC0, c, 2);
		wr(OFS_MODE, mode);
		wr(OFS_CTRL, ctrl);
	endtask : ch0

	task wait_wr(input int n);
		int k;
		k = 0;
		while (m.wa.size() < n && k < 3000) begin
			@(posedge ref_clk);
			k++;
		end
		chk("write count", 20'(m.wa.size()), 20'(n));
	endtask : wait_wr

	// per byte: destination address, data taken from the source, end pin, spacing
	task xfer_chk(input int b, input int n, input logic [19:0] s, input logic [19:0] d,
		input int ss, input int ds, input int per, input logic ios, input logic te);
		logic [19:0] sa;
		logic [7:0] e;
		for (int k = 0; k < n; k++) begin
			sa = s + 20'(ss * k);
			e = ios ? ~sa[7:0] : sa[7:0] ^ 8'hA5;
			chk("wr addr", m.wa[b + k], d + 20'(ds * k));
			chk("wr data", m.wd[b + k], e);
			if (te)
				chk("end pin", m.wte[b + k], k != n - 1);
			if (per != 0 && k > 0)
				chk("byte period", 20'(m.wt[b + k] - m.wt[b + k - 1]), 20'(per));
		end
	endtask : xfer_chk

	initial begin
		repeat (20000) @(posedge ref_clk);
		n_fail++;
		report_and_stop;
	end

	initial begin
		n_fail = 0;
		n_checks = 0;
		rst_n = 1'b0;
		io_addr = 8'h00;
		io_wdata = 8'h00;
		io_wr = 1'b0;
		io_rd = 1'b0;
		nmi_n = 1'b1;
		ch0_request_n = 1'b1;
		ch1_request_n = 1'b1;
		bus_grant = 1'b0;
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		rchk("status", OFS_STAT, 8'h30);
		rchk("mode", OFS_MODE, 8'h00);
		rchk("control", OFS_CTRL, 8'hF0);
		chk("mem wait", mem_wait_count, 2'h3);
		chk("io wait", io_wait_count, 2'h3);
		wr(OFS_STAT, 8'h7C);
		rchk("status", OFS_STAT, 8'h3C);
		chk("irq0", ch0_irq, 1'b1);
		chk("irq1", ch1_irq, 1'b1);
		rchk("unmapped", 8'h3F, 8'h00);
		// burst across a 64k boundary, destination counting down
		ch0(20'h0FFFF, 20'h1FFFE, 20'h3, 8'h12, 8'h00);
		wr(OFS_STAT, 8'h64);
		rchk("status", OFS_STAT, 8'h75);
		chk("irq0", ch0_irq, 1'b0);
		wait_wr(3);
		xfer_chk(0, 3, 20'h0FFFF, 20'h1FFFE, 1, -1, 6, 0, 1);
		repeat (10) @(posedge ref_clk);
		rchk("status", OFS_STAT, 8'h35);
		chk("irq0", ch0_irq, 1'b1);
		rchk("count0", OFS_BC0, 8'h00);
		rchk("src top", OFS_SAR + 8'h2, 8'h01);
		// cycle steal gives the cpu one cycle per byte
		ch0(20'h00040, 20'h00080, 20'h2, 8'h00, 8'h00);
		wr(OFS_STAT, 8'h60);
		wait_wr(5);
		xfer_chk(3, 2, 20'h00040, 20'h00080, 1, 1, 9, 0, 1);
		// one memory wait per access stretches each byte by two cycles
		ch0(20'h000A0, 20'h000C0, 20'h2, 8'h02, 8'h40);
		#1 chk("mem wait", mem_wait_count, 2'h1);
		wr(OFS_STAT, 8'h60);
		wait_wr(7);
		xfer_chk(5, 2, 20'h000A0, 20'h000C0, 1, 1, 8, 0, 1);
		// nmi in mid-run halts, a new enable write resumes
		ch0(20'h00050, 20'h00060, 20'h4, 8'h00, 8'h00);
		wr(OFS_STAT, 8'h60);
		wait_wr(8);
		nmi_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		nmi_n <= 1'b1;
		repeat (60) @(posedge ref_clk);
		rchk("status", OFS_STAT, 8'h70);
		nn = m.wa.size();
		repeat (60) @(posedge ref_clk);
		chk("halted", 20'(m.wa.size()), 20'(nn));
		chk("stopped early", nn < 11, 1'b1);
		wr(OFS_STAT, 8'h60);
		wait_wr(11);
		xfer_chk(7, 4, 20'h00050, 20'h00060, 1, 1, 0, 0, 1);
		// both channels start together: channel 0 first, then channel 1 i/o to memory
		ch0(20'h00010, 20'h00020, 20'h1, 8'h00, 8'h03);
		wreg(OFS_MAR, 20'h00035, 3);
		wreg(OFS_IAR, 20'h01234, 2);
		wreg(OFS_BC1, 20'h2, 2);
		ch1_request_n <= 1'b0;
		repeat (4) @(posedge ref_clk);
		wr(OFS_STAT, 8'hC0);
		wait_wr(14);
		chk("first mover", m.wa[11], 20'h00020);
		chk("end pin", m.wte[11], 1'b0);
		xfer_chk(12, 2, 20'h00034, 20'h00035, 0, -1, 0, 1, 0);
		ch1_request_n <= 1'b1;
		repeat (10) @(posedge ref_clk);
		rchk("status", OFS_STAT, 8'h31);
		rchk("mem addr1", OFS_MAR, 8'h33);
		rchk("io addr1", OFS_IAR, 8'h34);
		// edge-paced memory to i/o: one byte per falling edge of the request pin
		ch0(20'h00070, 20'h01242, 20'h2, 8'h30, 8'h04);
		wr(OFS_STAT, 8'h60);
		repeat (30) @(posedge ref_clk);
		chk("no edge no move", 20'(m.wa.size()), 20'h0000E);
		for (int p = 1; p <= 2; p++) begin
			ch0_request_n <= 1'b0;
			repeat (3) @(posedge ref_clk);
			ch0_request_n <= 1'b1;
			repeat (40) @(posedge ref_clk);
			chk("one per edge", 20'(m.wa.size()), 20'(14 + p));
		end
		xfer_chk(14, 2, 20'h00070, 20'h01242, 1, 0, 0, 0, 1);
		report_and_stop;
	end
endmodule : testbench

// ==== logic/tcdma_fifo.sv ====
// small flop-based fifo between the read and write halves of a byte move
// assumes one clock, source and sink both honour valid/ready
`timescale 1ns/1ps
module tcdma_fifo #(
	parameter int W = 8,
	parameter int D = 4
) (
	input logic ref_clk,
	input logic rst_n,
	input logic in_valid,
	output logic in_ready,
	input logic [W-1:0] in_data,
	output logic out_valid,
	input logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(D);
	localparam logic [AW:0] FULL = (AW+1)'(D);
	localparam logic [AW-1:0] LAST = (AW)'(D - 1);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} tcdma_fifo_state_t;

	tcdma_fifo_state_t r;
	tcdma_fifo_state_t n;
	logic push;
	logic pop;

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		return (p == LAST) ? '0 : p + 1'b1;
	endfunction : bump

	assign in_ready = (r.cnt != FULL);
	assign out_valid = (r.cnt != '0);
	assign out_data = r.mem[r.rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		n = r;
		if (push) begin
			n.mem[r.wp] = in_data;
			n.wp = bump(r.wp);
		end
		if (pop) begin
			n.rp = bump(r.rp);
		end
		if (push && !pop) begin
			n.cnt = r.cnt + 1'b1;
		end else if (pop && !push) begin
			n.cnt = r.cnt - 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end
endmodule : tcdma_fifo

// ==== logic/tcdma_pkg.sv ====
// constants and types shared by the two-channel transfer controller
// assumes an 8-bit internal i/o port from the cpu and a 100 MHz ref_clk
package tcdma_pkg;
	localparam int DATA_W = 8;
	localparam int MADDR_W = 20;
	localparam int IOADDR_W = 16;
	localparam int COUNT_W = 16;
	localparam int FIFO_DEPTH = 4;
	localparam int BYTE_CLKS = 6;

	localparam logic [7:0] OFS_SAR = 8'h20;
	localparam logic [7:0] OFS_DAR = 8'h23;
	localparam logic [7:0] OFS_BC0 = 8'h26;
	localparam logic [7:0] OFS_MAR = 8'h28;
	localparam logic [7:0] OFS_IAR = 8'h2B;
	localparam logic [7:0] OFS_BC1 = 8'h2E;
	localparam logic [7:0] OFS_STAT = 8'h30;
	localparam logic [7:0] OFS_MODE = 8'h31;
	localparam logic [7:0] OFS_CTRL = 8'h32;
	localparam logic [7:0] UNMAPPED_RD = 8'h00;

	localparam int STAT_DE1 = 7;
	localparam int STAT_DE0 = 6;
	localparam int STAT_WG1 = 5;
	localparam int STAT_WG0 = 4;
	localparam int STAT_IE1 = 3;
	localparam int STAT_IE0 = 2;
	localparam int STAT_ME = 0;
	localparam int MODE_DM_LSB = 4;
	localparam int MODE_SM_LSB = 2;
	localparam int MODE_BURST = 1;
	localparam int CTRL_MW_LSB = 6;
	localparam int CTRL_IW_LSB = 4;
	localparam int CTRL_RS_LSB = 2;
	localparam int CTRL_DIR_LSB = 0;

	localparam logic [1:0] AM_INC = 2'h0;
	localparam logic [1:0] AM_DEC = 2'h1;
	localparam logic [1:0] AM_FIX = 2'h2;
	localparam logic [1:0] AM_IO = 2'h3;
	localparam logic [1:0] MWAIT_RST = 2'h3;
	localparam logic [1:0] IWAIT_RST = 2'h3;
	// wait states per two-bit field value, field n in bits 2n+1:2n
	localparam logic [7:0] WAIT_MAP_DFLT = 8'hE4;

	typedef enum logic [3:0] {
		ST_IDLE, ST_REQ, ST_RT1, ST_RT2, ST_RTW, ST_RT3, ST_WT1, ST_WT2, ST_WTW, ST_WT3
	} tcdma_state_t;
endpackage : tcdma_pkg

// ==== logic/tcdma_top.sv ====
// two-channel byte mover sharing the system bus with the cpu
// assumes cpu grants the bus at machine-cycle boundaries; request and nmi pins are async
`timescale 1ns/1ps
//
// Behaviour
// - memory addresses are 20 bits, carry across 64k; i/o addresses 16 bits
// - each channel has a 16-bit count decremented once per byte
// - one byte per six clocks in burst without waits; wait fields stretch cycles
// - channel 0 wins when both channels want the bus
// - channel 1 runs while its enable and main enable are set; cleared at zero
// - channel 0 runs while its enable and main enable are set; cleared at zero
// - interrupt request while channel enable is 0 and its interrupt enable is 1
// - enable bit written only with its guard bit 0; guards read as 1
// - writing 1 to a channel enable sets main enable; main not directly writable
// - nmi clears main enable; a channel enable write of 1 restarts
// - channel 0 destination field: inc, dec, fixed memory, fixed i/o
// - channel 0 source field uses the same encoding, reset to 0
// - memory-to-memory ignores request pin; bit 1 picks burst or cycle steal
// - burst holds bus to the end; cycle steal frees bus after each byte
// - with i/o source or destination the request pin paces, burst bit ignored
// - memory and i/o wait fields stretch accesses, reset to all ones
// - request sense bits: 0 level, 1 edge, reset to 0
// - channel 1 direction field: mem-to-io or io-to-mem, inc or dec
// - a transfer-end pin tells external devices a channel 0 transfer finished
// - level request sampled in the state before the third write state
// - transfer-end goes low during channel 0's final byte write cycle, count zero
// - memory-to-memory starts one machine cycle after enabling
module tcdma_top #(
	parameter logic [7:0] WAIT_MAP = tcdma_pkg::WAIT_MAP_DFLT
) (
	input logic ref_clk,
	input logic rst_n,
	input logic [7:0] io_addr,
	input logic io_wr,
	input logic io_rd,
	input logic [tcdma_pkg::DATA_W-1:0] io_wdata,
	output logic [tcdma_pkg::DATA_W-1:0] io_rdata,
	input logic nmi_n,
	input logic ch0_request_n,
	input logic ch1_request_n,
	output logic bus_req,
	input logic bus_grant,
	output logic [tcdma_pkg::MADDR_W-1:0] dma_addr,
	output logic dma_is_io,
	output logic dma_rd,
	output logic dma_wr,
	output logic [tcdma_pkg::DATA_W-1:0] dma_wdata,
	input logic [tcdma_pkg::DATA_W-1:0] dma_rdata,
	output logic transfer_end_n,
	output logic ch0_irq,
	output logic ch1_irq,
	output logic [1:0] mem_wait_count,
	output logic [1:0] io_wait_count
);
	import tcdma_pkg::*;

	typedef struct packed {
		tcdma_state_t st;
		logic ch;
		logic [1:0] wcnt;
		logic samp;
		logic [MADDR_W-1:0] ch0_source_address;
		logic [MADDR_W-1:0] ch0_destination_address;
		logic [COUNT_W-1:0] ch0_byte_count;
		logic [MADDR_W-1:0] ch1_memory_address;
		logic [IOADDR_W-1:0] ch1_io_address;
		logic [COUNT_W-1:0] ch1_byte_count;
		logic de1, de0, ie1, ie0, master_transfer_enable;
		logic [1:0] dm, sm;
		logic burst_select;
		logic [1:0] mwi, iwi, dms, dim;
		logic r0a, r0b, r0c, r1a, r1b, r1c, nma, nmb, nmc;
		logic pend0, pend1;
		logic [MADDR_W-1:0] addr;
		logic io;
		logic [DATA_W-1:0] wdata;
		logic [DATA_W-1:0] rdata;
	} tcdma_regs_t;

	tcdma_regs_t r;
	tcdma_regs_t n;
	logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
	logic [DATA_W-1:0] f_out_data;
	logic s0_io, d0_io, m2m, req0_ok, req1_ok, go0, go1;
	logic start, sel, cont, cur_done, cur_de, wphase;
	logic [MADDR_W-1:0] src_a, dst_a;
	logic src_io, dst_io;

	function automatic logic [MADDR_W-1:0] step(input logic [MADDR_W-1:0] a,
			input logic [1:0] m);
		// full 20-bit add so 64k crossings need no help
		case (m)
			AM_INC: return a + 20'h00001;
			AM_DEC: return a - 20'h00001;
			default: return a;
		endcase
	endfunction : step

	function automatic logic [MADDR_W-1:0] put(input logic [MADDR_W-1:0] a, input logic io);
		return io ? {4'h0, a[IOADDR_W-1:0]} : a;
	endfunction : put

	function automatic logic [1:0] wait_of(input logic [1:0] f);
		return WAIT_MAP[{f, 1'b0} +: 2];
	endfunction : wait_of

	function automatic logic hit(input logic [7:0] a, input logic [7:0] base,
			input logic [7:0] len);
		return (a >= base) && (a < 8'(base + len));
	endfunction : hit

	function automatic logic [MADDR_W-1:0] wr20(input logic [MADDR_W-1:0] v,
			input logic [1:0] i, input logic [7:0] d);
		logic [MADDR_W-1:0] t;
		t = v;
		case (i)
			2'h0: t[7:0] = d;
			2'h1: t[15:8] = d;
			default: t[19:16] = d[3:0];
		endcase
		return t;
	endfunction : wr20

	function automatic logic [7:0] rd20(input logic [MADDR_W-1:0] v, input logic [1:0] i);
		case (i)
			2'h0: return v[7:0];
			2'h1: return v[15:8];
			default: return {4'h0, v[19:16]};
		endcase
	endfunction : rd20

	// channel qualification from the registered state
	assign s0_io = (r.sm == AM_IO);
	assign d0_io = (r.dm == AM_IO);
	assign m2m = !s0_io && !d0_io;
	assign req0_ok = r.dms[0] ? r.pend0 : !r.r0b;
	assign req1_ok = r.dms[1] ? r.pend1 : !r.r1b;
	assign go0 = r.de0 && r.master_transfer_enable && (m2m || req0_ok);
	assign go1 = r.de1 && r.master_transfer_enable && req1_ok;
	assign cur_done = r.ch ? (r.ch1_byte_count == '0) : (r.ch0_byte_count == '0);
	assign cur_de = r.ch ? r.de1 : r.de0;
	// source follows the selected channel, destination the active one
	assign src_a = sel ? (r.dim[1] ? {4'h0, r.ch1_io_address} : r.ch1_memory_address) : r.ch0_source_address;
	assign src_io = sel ? r.dim[1] : s0_io;
	assign dst_a = r.ch ? (r.dim[1] ? r.ch1_memory_address : {4'h0, r.ch1_io_address}) : r.ch0_destination_address;
	assign dst_io = r.ch ? !r.dim[1] : d0_io;

	always_comb begin
		n = r;
		f_in_valid = 1'b0;
		f_out_ready = 1'b0;
		start = 1'b0;
		sel = 1'b0;
		cont = 1'b0;
		// two-stage synchronisers, third stage only for edge detection
		n.r0a = ch0_request_n;
		n.r0b = r.r0a;
		n.r0c = r.r0b;
		n.r1a = ch1_request_n;
		n.r1b = r.r1a;
		n.r1c = r.r1b;
		n.nma = nmi_n;
		n.nmb = r.nma;
		n.nmc = r.nmb;
		case (r.st)
			ST_IDLE: begin
				if (go0 || go1) begin
					n.st = ST_REQ;
				end
			end
			ST_REQ: begin
				if (!(go0 || go1)) begin
					n.st = ST_IDLE;
				end else if (bus_grant) begin
					start = 1'b1;
					sel = !go0;
				end
			end
			ST_RT1: n.st = ST_RT2;
			ST_RT2, ST_RTW: begin
				if (r.wcnt == 2'h0) begin
					n.st = ST_RT3;
				end else begin
					n.st = ST_RTW;
					n.wcnt = r.wcnt - 2'h1;
				end
			end
			ST_RT3: begin
				f_in_valid = 1'b1;
				if (f_in_ready) begin
					n.st = ST_WT1;
					n.addr = put(dst_a, dst_io);
					n.io = dst_io;
					n.wcnt = wait_of(dst_io ? r.iwi : r.mwi);
					if (!r.ch) begin
						n.ch0_source_address = step(r.ch0_source_address, r.sm);
						n.ch0_byte_count = r.ch0_byte_count - 16'h0001;
					end else begin
						if (!r.dim[1]) begin
							n.ch1_memory_address = step(r.ch1_memory_address, {1'b0, r.dim[0]});
						end
						n.ch1_byte_count = r.ch1_byte_count - 16'h0001;
					end
				end
			end
			ST_WT1: begin
				// write waits here if the buffered byte is not yet out
				f_out_ready = 1'b1;
				if (f_out_valid) begin
					n.wdata = f_out_data;
					n.st = ST_WT2;
				end
			end
			ST_WT2, ST_WTW: begin
				n.samp = r.ch ? req1_ok : req0_ok;
				if (r.wcnt == 2'h0) begin
					n.st = ST_WT3;
				end else begin
					n.st = ST_WTW;
					n.wcnt = r.wcnt - 2'h1;
				end
			end
			ST_WT3: begin
				if (!r.ch) begin
					n.ch0_destination_address = step(r.ch0_destination_address, r.dm);
					if (r.ch0_byte_count == '0) begin
						n.de0 = 1'b0;
					end
				end else begin
					if (r.dim[1]) begin
						n.ch1_memory_address = step(r.ch1_memory_address, {1'b0, r.dim[0]});
					end
					if (r.ch1_byte_count == '0) begin
						n.de1 = 1'b0;
					end
				end
				cont = (!r.ch && m2m) ? r.burst_select : r.samp;
				if (cont && !cur_done && r.master_transfer_enable && cur_de) begin
					start = 1'b1;
					sel = go0 ? 1'b0 : r.ch;
				end else begin
					n.st = ST_IDLE; // bus back at the boundary
				end
			end
			default: n.st = ST_IDLE;
		endcase
		if (start) begin
			n.ch = sel;
			n.st = ST_RT1;
			n.addr = put(src_a, src_io);
			n.io = src_io;
			n.wcnt = wait_of(src_io ? r.iwi : r.mwi);
			if (sel) begin
				n.pend1 = 1'b0;
			end else begin
				n.pend0 = 1'b0;
			end
		end
		// software writes override hardware updates of the same register, except an nmi edge clearing main enable
		if (io_wr) begin
			if (hit(io_addr, OFS_SAR, 8'h03)) n.ch0_source_address = wr20(r.ch0_source_address, 2'(io_addr - OFS_SAR), io_wdata);
			if (hit(io_addr, OFS_DAR, 8'h03)) n.ch0_destination_address = wr20(r.ch0_destination_address, 2'(io_addr - OFS_DAR), io_wdata);
			if (hit(io_addr, OFS_MAR, 8'h03)) n.ch1_memory_address = wr20(r.ch1_memory_address, 2'(io_addr - OFS_MAR), io_wdata);
			if (io_addr == OFS_BC0) n.ch0_byte_count[7:0] = io_wdata;
			if (io_addr == 8'(OFS_BC0 + 8'h01)) n.ch0_byte_count[15:8] = io_wdata;
			if (io_addr == OFS_IAR) n.ch1_io_address[7:0] = io_wdata;
			if (io_addr == 8'(OFS_IAR + 8'h01)) n.ch1_io_address[15:8] = io_wdata;
			if (io_addr == OFS_BC1) n.ch1_byte_count[7:0] = io_wdata;
			if (io_addr == 8'(OFS_BC1 + 8'h01)) n.ch1_byte_count[15:8] = io_wdata;
			if (io_addr == OFS_STAT) begin
				if (!io_wdata[STAT_WG1]) begin
					n.de1 = io_wdata[STAT_DE1];
					if (io_wdata[STAT_DE1]) n.master_transfer_enable = 1'b1;
				end
				if (!io_wdata[STAT_WG0]) begin
					n.de0 = io_wdata[STAT_DE0];
					if (io_wdata[STAT_DE0]) n.master_transfer_enable = 1'b1;
				end
				n.ie1 = io_wdata[STAT_IE1];
				n.ie0 = io_wdata[STAT_IE0];
			end
			if (io_addr == OFS_MODE) begin
				n.dm = io_wdata[MODE_DM_LSB +: 2];
				n.sm = io_wdata[MODE_SM_LSB +: 2];
				n.burst_select = io_wdata[MODE_BURST];
			end
			if (io_addr == OFS_CTRL) begin
				n.mwi = io_wdata[CTRL_MW_LSB +: 2];
				n.iwi = io_wdata[CTRL_IW_LSB +: 2];
				n.dms = io_wdata[CTRL_RS_LSB +: 2];
				n.dim = io_wdata[CTRL_DIR_LSB +: 2];
			end
		end
		// a falling edge in the clearing cycle still counts
		if (r.r0c && !r.r0b) n.pend0 = 1'b1;
		if (r.r1c && !r.r1b) n.pend1 = 1'b1;
		if (r.nmc && !r.nmb) n.master_transfer_enable = 1'b0;
		if (io_rd) begin
			n.rdata = UNMAPPED_RD;
			if (hit(io_addr, OFS_SAR, 8'h03)) n.rdata = rd20(r.ch0_source_address, 2'(io_addr - OFS_SAR));
			if (hit(io_addr, OFS_DAR, 8'h03)) n.rdata = rd20(r.ch0_destination_address, 2'(io_addr - OFS_DAR));
			if (hit(io_addr, OFS_MAR, 8'h03)) n.rdata = rd20(r.ch1_memory_address, 2'(io_addr - OFS_MAR));
			if (io_addr == OFS_BC0) n.rdata = r.ch0_byte_count[7:0];
			if (io_addr == 8'(OFS_BC0 + 8'h01)) n.rdata = r.ch0_byte_count[15:8];
			if (io_addr == OFS_IAR) n.rdata = r.ch1_io_address[7:0];
			if (io_addr == 8'(OFS_IAR + 8'h01)) n.rdata = r.ch1_io_address[15:8];
			if (io_addr == OFS_BC1) n.rdata = r.ch1_byte_count[7:0];
			if (io_addr == 8'(OFS_BC1 + 8'h01)) n.rdata = r.ch1_byte_count[15:8];
			if (io_addr == OFS_STAT) n.rdata = {r.de1, r.de0, 2'b11, r.ie1, r.ie0, 1'b0, r.master_transfer_enable};
			if (io_addr == OFS_MODE) n.rdata = {2'b00, r.dm, r.sm, r.burst_select, 1'b0};
			if (io_addr == OFS_CTRL) n.rdata = {r.mwi, r.iwi, r.dms, r.dim};
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
			r.mwi <= MWAIT_RST;
			r.iwi <= IWAIT_RST;
			{r.r0a, r.r0b, r.r0c, r.r1a, r.r1b, r.r1c} <= 6'h3F;
			{r.nma, r.nmb, r.nmc} <= 3'h7;
		end else begin
			r <= n;
		end
	end

	// read data parks in the fifo so a stalled write stalls the read side
	tcdma_fifo #(.W(DATA_W), .D(FIFO_DEPTH)) u_fifo (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.in_valid(f_in_valid),
		.in_ready(f_in_ready),
		.in_data(dma_rdata),
		.out_valid(f_out_valid),
		.out_ready(f_out_ready),
		.out_data(f_out_data)
	);

	assign wphase = (r.st == ST_WT1) || (r.st == ST_WT2) || (r.st == ST_WTW) || (r.st == ST_WT3);
	assign bus_req = (r.st != ST_IDLE);
	assign dma_addr = r.addr;
	assign dma_is_io = r.io;
	assign dma_rd = (r.st == ST_RT1) || (r.st == ST_RT2) || (r.st == ST_RTW) || (r.st == ST_RT3);
	assign dma_wr = wphase && (r.st != ST_WT1);
	assign dma_wdata = r.wdata;
	assign transfer_end_n = !(wphase && !r.ch && (r.ch0_byte_count == '0));
	assign ch0_irq = !r.de0 && r.ie0;
	assign ch1_irq = !r.de1 && r.ie1;
	assign mem_wait_count = r.mwi;
	assign io_wait_count = r.iwi;
	assign io_rdata = r.rdata;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	property p_irq_on_end;
		(r.ie0 && $fell(r.de0)) |-> ch0_irq;
	endproperty
	a_irq_on_end: assert property (p_irq_on_end) else $error("ch0 end without irq");
	property p_prio;
		(r.st == ST_REQ && go0 && go1 && bus_grant) |=> (r.st == ST_RT1 && !r.ch);
	endproperty
	a_prio: assert property (p_prio) else $error("channel 1 won a tie");
	property p_read_len;
		(r.st == ST_RT1 && r.wcnt == 2'h0) |-> ##2 (r.st == ST_RT3);
	endproperty
	a_read_len: assert property (p_read_len) else $error("zero-wait read not 3 clocks");
	property p_count_dec;
		(r.st == ST_RT3 && f_in_ready && !r.ch && !io_wr) |=> (r.ch0_byte_count == $past(r.ch0_byte_count) - 16'h0001);
	endproperty
	a_count_dec: assert property (p_count_dec) else $error("count not decremented");
	property p_tend;
		(r.st == ST_RT3 && f_in_ready && !r.ch && r.ch0_byte_count == 16'h0001) |=> !transfer_end_n[*2];
	endproperty
	a_tend: assert property (p_tend) else $error("transfer end missing");
	property p_de0_off;
		(r.st == ST_WT3 && !r.ch && r.ch0_byte_count == '0 && !io_wr) |=> !r.de0;
	endproperty
	a_de0_off: assert property (p_de0_off) else $error("ch0 enable kept");
	property p_de1_off;
		(r.st == ST_WT3 && r.ch && r.ch1_byte_count == '0 && !io_wr) |=> !r.de1;
	endproperty
	a_de1_off: assert property (p_de1_off) else $error("ch1 enable kept");
	property p_nmi;
		(r.nmc && !r.nmb) |=> !r.master_transfer_enable;
	endproperty
	a_nmi: assert property (p_nmi) else $error("nmi left main enable");
	property p_guard;
		(io_wr && io_addr == OFS_STAT && io_wdata[STAT_WG0] && r.st != ST_WT3) |=> $stable(r.de0);
	endproperty
	a_guard: assert property (p_guard) else $error("guarded enable changed");
	property p_steal;
		(r.st == ST_WT3 && !r.ch && m2m && !r.burst_select) |=> (r.st == ST_IDLE) && !bus_req;
	endproperty
	a_steal: assert property (p_steal) else $error("cycle steal kept bus");
	c_burst: cover property ((r.st == ST_WT3 && r.burst_select && m2m) ##1 (r.st == ST_RT1));
	c_ch1_done: cover property ($fell(r.de1));
	c_stall: cover property (r.st == ST_WT1 && !f_out_valid);
endmodule : tcdma_top
